// ---- sff_defines.svh ----
// Register indices, field positions, reset values and sizes of the SPI FIFO flag block.
// Assumes inclusion by bare name from the block's design files.
`ifndef SFF_DEFINES_SVH
`define SFF_DEFINES_SVH

// Register indices; byte address is four times the index
`define SFF_IDX_CTRL 10'h098
`define SFF_IDX_STAT 10'h099
`define SFF_IDX_RXD 10'h09A
`define SFF_IDX_TXD 10'h09B

// Status bit positions
`define SFF_ST_OVR 7
`define SFF_ST_RXNE 6
`define SFF_ST_TXF 5
`define SFF_ST_TXE 4
`define SFF_ST_TXFL 3
`define SFF_ST_EXPD 2

// Reset values
`define SFF_CTRL_RST 8'h00
`define SFF_ESS_RST 8'hFF
`define SFF_IDLE_BYTE 8'hFF

// Bus responses
`define SFF_RESP_OKAY 2'b00
`define SFF_RESP_SLVERR 2'b10

// FIFO geometry
`define SFF_FIFO_DEPTH 12
`define SFF_PTR_W 4

`endif

// ---- sff_pkg.sv ----
// Types shared by the SPI FIFO flag block.
// Assumes nothing beyond a SystemVerilog compiler.
package sff_pkg;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic rx_irq_enable;
        logic tx_irq_enable;
        logic expander_detect_enable;
        logic [1:0] operating_mode_select;
        logic active_edge_select;
        logic spi_enable;
        logic loop_back;
    } sff_ctrl_t;

    // Serial pins as they arrive
    typedef struct packed {
        logic sck;
        logic mosi;
        logic ss_n;
    } sff_pins_t;

endpackage : sff_pkg

// ---- sff_sync.sv ----
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes the inputs are quasi-static relative to clk_i.
module sff_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            // Idle pin levels, so no false edge follows reset
            meta_r <= RST_VAL;
            q_o <= RST_VAL;
        end
        else
        begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end

endmodule : sff_sync

// ---- sff_fifo_mem.sv ----
// Byte storage for one FIFO: one write port, two asynchronous read ports.
// Assumes the addresses stay below DEPTH.
module sff_fifo_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 12,
    parameter int AW = 4
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_a_i,
    output logic [WIDTH-1:0] rdata_a_o,
    input wire logic [AW-1:0] raddr_b_i,
    output logic [WIDTH-1:0] rdata_b_o
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
    end

    assign rdata_a_o = mem[raddr_a_i];
    assign rdata_b_o = mem[raddr_b_i];

endmodule : sff_fifo_mem

// ---- sff_top.sv ----
// SPI slave with 12-byte receive and transmit FIFOs, their flags and the select expander.
// Assumes an AXI4-Lite master on clk_i and asynchronous SPI pins from an external master.
//
// Chosen here: the AXI4-Lite register port.
`include "sff_defines.svh"

module sff_top #(
    parameter int DEPTH = `SFF_FIFO_DEPTH,
    parameter int PW = `SFF_PTR_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [11:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [11:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic ss_n_i,
    output logic miso_o,
    output logic miso_oe_o,
    output logic [7:0] expanded_select_outputs_o,
    output logic expander_mode_o,
    output logic rx_irq_o,
    output logic tx_irq_o
);

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    sff_pkg::sff_pins_t pins_raw;
    sff_pkg::sff_pins_t pins_s;
    logic sck_d_r;
    logic ss_d_r;

    assign pins_raw = '{sck: sck_i, mosi: mosi_i, ss_n: ss_n_i};

    sff_sync #(
        .WIDTH(3),
        .RST_VAL(3'b011)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pins_raw),
        .q_o(pins_s)
    );

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sck_d_r <= 1'b0;
            ss_d_r <= 1'b1;
        end
        else
        begin
            sck_d_r <= pins_s.sck;
            ss_d_r <= pins_s.ss_n;
        end
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    sff_pkg::sff_ctrl_t ctrl_r;
    logic [PW-1:0] rx_wp_r, rx_rp_r, tx_wp_r, tx_rp_r;
    logic rx_full_r, tx_full_r, tx_empty_r, rx_ovr_r, tx_flushed_r;
    logic exp_mode_r, exp_first_r, exp_det_r, armed_r, tx_busy_r;
    logic [7:0] ess_r, rx_shift_r, tx_shift_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] rx_rd_data, tx_rd_data, tx_sw_data;
    logic aw_have_r, w_have_r, bvalid_nxt, rvalid_nxt, aw_have_nxt, w_have_nxt;
    logic [9:0] aw_idx_r;
    logic [7:0] wdata_q_r;
    logic wstrb0_q_r;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : ptr_inc

    // ------------------------------------------------------------
    // Serial events
    // ------------------------------------------------------------
    logic sck_rise, sck_fall, sample_edge, shift_edge, ss_fall, ss_rise;
    logic active, byte_done, load_evt;
    logic [7:0] rx_byte;

    assign sck_rise = pins_s.sck & ~sck_d_r;
    assign sck_fall = ~pins_s.sck & sck_d_r;
    assign sample_edge = ctrl_r.active_edge_select ? sck_fall : sck_rise;
    assign shift_edge = ctrl_r.active_edge_select ? sck_rise : sck_fall;
    assign ss_fall = ~pins_s.ss_n & ss_d_r;
    assign ss_rise = pins_s.ss_n & ~ss_d_r;
    assign active = ctrl_r.spi_enable & armed_r & ~pins_s.ss_n;
    assign byte_done = active & sample_edge & (bit_cnt_r == 3'd7);
    assign rx_byte = {rx_shift_r[6:0], pins_s.mosi};
    assign load_evt = (active & ss_fall) | byte_done;

    // ------------------------------------------------------------
    // Software events
    // ------------------------------------------------------------
    logic wr_fire, ar_take, aw_take, w_take;
    logic [9:0] ar_idx;
    logic sw_stat_wr, sw_txd_wr, sw_tx_wr, sw_rx_rd;
    logic rx_not_empty, tx_avail;

    assign aw_take = s_axi_awvalid_i & s_axi_awready_o;
    assign w_take = s_axi_wvalid_i & s_axi_wready_o;
    assign ar_take = s_axi_arvalid_i & s_axi_arready_o;
    assign ar_idx = s_axi_araddr_i[11:2];
    assign wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid_o;
    assign sw_stat_wr = wr_fire & (aw_idx_r == `SFF_IDX_STAT);
    assign sw_txd_wr = wr_fire & wstrb0_q_r & (aw_idx_r == `SFF_IDX_TXD);
    assign sw_tx_wr = sw_txd_wr & ctrl_r.spi_enable & ~tx_full_r;
    assign rx_not_empty = (rx_wp_r != rx_rp_r) | rx_full_r;
    assign tx_avail = (tx_wp_r != tx_rp_r) | tx_full_r;
    assign sw_rx_rd = ar_take & (ar_idx == `SFF_IDX_RXD) & ctrl_r.spi_enable & rx_not_empty;

    // ------------------------------------------------------------
    // Receive FIFO
    // ------------------------------------------------------------
    logic rx_attempt, rx_wr, ovr_set, ovr_clr;

    assign rx_attempt = byte_done & ~exp_mode_r;
    assign rx_wr = rx_attempt & ~rx_full_r & ~rx_ovr_r;
    assign ovr_set = rx_attempt & rx_full_r;
    assign ovr_clr = sw_stat_wr & rx_ovr_r & ~ovr_set;

    sff_fifo_mem #(
        .WIDTH(8),
        .DEPTH(DEPTH),
        .AW(PW)
    ) u_rx_mem (
        .clk_i(clk_i),
        .we_i(rx_wr),
        .waddr_i(rx_wp_r),
        .wdata_i(rx_byte),
        .raddr_a_i(rx_rp_r),
        .rdata_a_o(rx_rd_data),
        .raddr_b_i(rx_rp_r),
        .rdata_b_o()
    );

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_wp_r <= '0;
            rx_rp_r <= '0;
            rx_full_r <= 1'b0;
        end
        else if (!ctrl_r.spi_enable || ovr_clr)
        begin
            rx_wp_r <= '0;
            rx_rp_r <= '0;
            rx_full_r <= 1'b0;
        end
        else
        begin
            if (rx_wr)
            begin
                rx_wp_r <= ptr_inc(rx_wp_r);
            end
            if (sw_rx_rd)
            begin
                rx_rp_r <= ptr_inc(rx_rp_r);
            end
            if (rx_wr && !sw_rx_rd && (ptr_inc(rx_wp_r) == rx_rp_r))
            begin
                rx_full_r <= 1'b1;
            end
            else if (sw_rx_rd)
            begin
                rx_full_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_ovr_r <= 1'b0;
        end
        else if (ovr_set)
        begin
            rx_ovr_r <= 1'b1;
        end
        else if (sw_stat_wr)
        begin
            rx_ovr_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Transmit FIFO
    // ------------------------------------------------------------
    logic tx_rd, flush;

    assign tx_rd = load_evt & tx_avail;
    assign flush = ss_rise & ctrl_r.spi_enable & (tx_avail | tx_busy_r);

    sff_fifo_mem #(
        .WIDTH(8),
        .DEPTH(DEPTH),
        .AW(PW)
    ) u_tx_mem (
        .clk_i(clk_i),
        .we_i(sw_tx_wr),
        .waddr_i(tx_wp_r),
        .wdata_i(wdata_q_r),
        .raddr_a_i(tx_rp_r),
        .rdata_a_o(tx_rd_data),
        .raddr_b_i(tx_wp_r),
        .rdata_b_o(tx_sw_data)
    );

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_wp_r <= '0;
            tx_rp_r <= '0;
            tx_full_r <= 1'b0;
            tx_empty_r <= 1'b1;
        end
        else if (!ctrl_r.spi_enable || flush)
        begin
            tx_wp_r <= '0;
            tx_rp_r <= '0;
            tx_full_r <= 1'b0;
            tx_empty_r <= 1'b1;
        end
        else
        begin
            if (sw_tx_wr)
            begin
                tx_wp_r <= ptr_inc(tx_wp_r);
            end
            if (tx_rd)
            begin
                tx_rp_r <= ptr_inc(tx_rp_r);
            end
            if (sw_tx_wr && !tx_rd && (ptr_inc(tx_wp_r) == tx_rp_r))
            begin
                tx_full_r <= 1'b1;
            end
            else if (tx_rd)
            begin
                tx_full_r <= 1'b0;
            end
            if (tx_rd && !sw_tx_wr && (ptr_inc(tx_rp_r) == tx_wp_r))
            begin
                tx_empty_r <= 1'b1;
            end
            else if (sw_tx_wr)
            begin
                tx_empty_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_flushed_r <= 1'b0;
        end
        else if (flush)
        begin
            tx_flushed_r <= 1'b1;
        end
        else if (sw_txd_wr)
        begin
            tx_flushed_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            armed_r <= 1'b0;
            bit_cnt_r <= 3'd0;
            rx_shift_r <= 8'h00;
            tx_shift_r <= `SFF_IDLE_BYTE;
            tx_busy_r <= 1'b0;
        end
        else
        begin
            // Hold off shifting until select has been seen inactive
            if (!ctrl_r.spi_enable)
            begin
                armed_r <= 1'b0;
            end
            else if (pins_s.ss_n)
            begin
                armed_r <= 1'b1;
            end
            if (!active)
            begin
                bit_cnt_r <= 3'd0;
            end
            else if (sample_edge)
            begin
                bit_cnt_r <= bit_cnt_r + 3'd1;
                rx_shift_r <= rx_byte;
            end
            if (load_evt)
            begin
                tx_shift_r <= tx_rd ? tx_rd_data : `SFF_IDLE_BYTE;
                tx_busy_r <= tx_rd;
            end
            else if (active && shift_edge && (bit_cnt_r != 3'd0))
            begin
                tx_shift_r <= {tx_shift_r[6:0], 1'b1};
            end
            else if (ss_rise)
            begin
                tx_busy_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Select expander
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            exp_mode_r <= 1'b0;
            exp_first_r <= 1'b0;
            exp_det_r <= 1'b0;
            ess_r <= `SFF_ESS_RST;
        end
        else if (ss_rise)
        begin
            exp_mode_r <= 1'b0;
            exp_first_r <= 1'b0;
            exp_det_r <= 1'b0;
            ess_r <= `SFF_ESS_RST;
        end
        else if (active && ss_fall)
        begin
            exp_mode_r <= ctrl_r.expander_detect_enable & ~pins_s.mosi;
            exp_first_r <= 1'b1;
        end
        else if (byte_done && exp_mode_r && exp_first_r)
        begin
            ess_r <= rx_byte;
            exp_det_r <= 1'b1;
            exp_first_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pin and interrupt outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            miso_o <= 1'b1;
            miso_oe_o <= 1'b0;
            expanded_select_outputs_o <= `SFF_ESS_RST;
            expander_mode_o <= 1'b0;
            rx_irq_o <= 1'b0;
            tx_irq_o <= 1'b0;
        end
        else
        begin
            miso_o <= active ? tx_shift_r[7] : 1'b1;
            miso_oe_o <= active;
            expanded_select_outputs_o <= ess_r;
            expander_mode_o <= exp_mode_r;
            rx_irq_o <= ctrl_r.rx_irq_enable & (rx_ovr_r | rx_not_empty);
            tx_irq_o <= ctrl_r.tx_irq_enable & (tx_wp_r == tx_rp_r) & tx_empty_r;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic [7:0] status_byte;
    logic ar_mapped, aw_mapped;

    assign status_byte = {rx_ovr_r, rx_not_empty, tx_full_r, tx_empty_r,
                          tx_flushed_r, exp_det_r, 2'b00};
    assign ar_mapped = (ar_idx >= `SFF_IDX_CTRL) && (ar_idx <= `SFF_IDX_TXD);
    assign aw_mapped = (aw_idx_r >= `SFF_IDX_CTRL) && (aw_idx_r <= `SFF_IDX_TXD);
    assign aw_have_nxt = wr_fire ? 1'b0 : (aw_have_r | aw_take);
    assign w_have_nxt = wr_fire ? 1'b0 : (w_have_r | w_take);
    assign bvalid_nxt = wr_fire | (s_axi_bvalid_o & ~s_axi_bready_i);
    assign rvalid_nxt = ar_take | (s_axi_rvalid_o & ~s_axi_rready_i);

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_idx_r <= 10'h000;
            wdata_q_r <= 8'h00;
            wstrb0_q_r <= 1'b0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `SFF_RESP_OKAY;
        end
        else
        begin
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            s_axi_awready_o <= ~aw_have_nxt & ~bvalid_nxt;
            s_axi_wready_o <= ~w_have_nxt & ~bvalid_nxt;
            s_axi_bvalid_o <= bvalid_nxt;
            if (aw_take)
            begin
                aw_idx_r <= s_axi_awaddr_i[11:2];
            end
            if (w_take)
            begin
                wdata_q_r <= s_axi_wdata_i[7:0];
                wstrb0_q_r <= s_axi_wstrb_i[0];
            end
            if (wr_fire)
            begin
                s_axi_bresp_o <= aw_mapped ? `SFF_RESP_OKAY : `SFF_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_r <= `SFF_CTRL_RST;
        end
        else if (wr_fire && wstrb0_q_r && (aw_idx_r == `SFF_IDX_CTRL))
        begin
            ctrl_r <= wdata_q_r;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= `SFF_RESP_OKAY;
        end
        else
        begin
            s_axi_arready_o <= ~rvalid_nxt;
            s_axi_rvalid_o <= rvalid_nxt;
            if (ar_take)
            begin
                s_axi_rresp_o <= ar_mapped ? `SFF_RESP_OKAY : `SFF_RESP_SLVERR;
                case (ar_idx)
                    `SFF_IDX_CTRL: s_axi_rdata_o <= {24'h00_0000, ctrl_r};
                    `SFF_IDX_STAT: s_axi_rdata_o <= {24'h00_0000, status_byte};
                    `SFF_IDX_RXD: s_axi_rdata_o <= {24'h00_0000, rx_rd_data};
                    `SFF_IDX_TXD: s_axi_rdata_o <= {24'h00_0000, tx_sw_data};
                    default: s_axi_rdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : sff_top

// ---- sff_top_sva.sv ----
// Checker of bus handshakes and pin idle levels of sff_top.
// Assumes it is bound to sff_top and sees only its ports.
module sff_top_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic ss_n_i,
    input wire logic miso_o,
    input wire logic miso_oe_o,
    input wire logic [7:0] expanded_select_outputs_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("write answer dropped early");
    chk_b_time: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |-> ##[1:3] s_axi_bvalid_o)
        else $error("write answer late");
    chk_b_code: assert property (s_axi_bvalid_o |-> s_axi_bresp_o inside {2'b00, 2'b10})
        else $error("bad write response");
    chk_aw_drop: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o)
        else $error("second write address open");
    chk_r_next: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
    chk_r_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000)
        else $error("read upper bits set");
    chk_miso_idle: assert property (!miso_oe_o |-> miso_o)
        else $error("idle serial out not high");
    chk_oe_off: assert property (ss_n_i [*6] |-> !miso_oe_o)
        else $error("serial out driven while deselected");
    chk_ess_idle: assert property (ss_n_i [*6] |-> expanded_select_outputs_o == 8'hFF)
        else $error("expander outputs not released");
endmodule : sff_top_sva

bind sff_top sff_top_sva i_sva (.*);

// ---- sff_spi_master.sv ----
// SPI master model: samples on rising SCK, or on falling SCK when edge_sel is set, MSB first, clock still outside frames.
// Assumes the bench calls its tasks one at a time.
module sff_spi_master (
    output logic sck_o,
    output logic mosi_o,
    output logic ss_n_o,
    input wire logic miso_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // 0: sample on rising SCK, 1: sample on falling SCK
    logic edge_sel = 1'b0;
    initial
    begin
        sck_o = 1'b0;
        mosi_o = 1'b1;
        ss_n_o = 1'b1;
    end
    // Select with a chosen data level at the fall
    task sel(input logic lvl);
        // Offset keeps pin changes away from the sampling clock edge
        #12 mosi_o = lvl;
        #400 ss_n_o = 1'b0;
        #400;
    endtask : sel
    // One byte each way, 400 ns per bit
    task xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int k = 7; k >= 0; k--)
        begin
            if (!edge_sel)
                mosi_o = tx[k];
            #200 sck_o = 1'b1;
            if (edge_sel)
                mosi_o = tx[k];
            else
                rx[k] = miso_i;
            #200;
            if (edge_sel)
                rx[k] = miso_i;
            sck_o = 1'b0;
        end
    endtask : xfer
    // Release select; data line stops holding its value
    task desel;
        #412 ss_n_o = 1'b1;
        mosi_o = ~mosi_o;
        // Let the select rise reach the flags
        #400;
    endtask : desel
endmodule : sff_spi_master

// ---- test_spi_fifo_status_flags.sv ----
// Self-checking bench of sff_top driven by an SPI master model.
// Assumes sff_top, the checker and sff_spi_master are compiled first.
`include "sff_defines.svh"
module test_spi_fifo_status_flags;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [11:0] s_axi_awaddr_i = 12'h000, s_axi_araddr_i = 12'h000;
    logic [31:0] s_axi_wdata_i = 32'h0000_0000;
    logic [3:0] s_axi_wstrb_i = 4'h1;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r, rr;
    logic [31:0] s_axi_rdata_o, seed = 32'hc58c_4712;
    logic miso_o, miso_oe_o, expander_mode_o, rx_irq_o, tx_irq_o;
    logic [7:0] expanded_select_outputs_o, v;
    logic [7:0] txq [13];
    logic [7:0] rxq [13];
    wire sck_i, mosi_i, ss_n_i;
    int bad_count = 0, check_count = 0, cyc = 0, i;
    sff_top i_dut (.*);
    sff_spi_master i_mst (.sck_o(sck_i), .mosi_o(mosi_i), .ss_n_o(ss_n_i), .miso_i(miso_o));
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end
    // ----------------------------------------
    // Bus tasks and expectations
    // ----------------------------------------
    function logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    function logic [7:0] sta(input logic [5:0] f);
        return {f, 2'b00};
    endfunction : sta
    task chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [9:0] ix, input logic [7:0] d, output logic [1:0] rs);
        @(posedge clk_i);
        s_axi_awaddr_i <= {ix, 2'b00};
        s_axi_wdata_i <= {24'h00_0000, d};
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end
        while (s_axi_bvalid_o !== 1'b1);
        rs = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
    endtask : wr
    task rd(input logic [9:0] ix, output logic [7:0] d);
        @(posedge clk_i);
        s_axi_araddr_i <= {ix, 2'b00};
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end
        while (s_axi_rvalid_o !== 1'b1);
        d = s_axi_rdata_o[7:0];
        rr = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
    endtask : rd
    task st(input logic [5:0] f);
        rd(`SFF_IDX_STAT, v);
        chk(v, sta(f));
    endtask : st
    task end_sim;
        $display("checks %0d bad %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            end_sim;
        end
    end
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        st(6'b000100);
        wr(`SFF_IDX_CTRL, 8'hC2, r);
        rd(`SFF_IDX_CTRL, v);
        chk(v, 8'hC2);
        chk({6'h00, rr}, {6'h00, `SFF_RESP_OKAY});
        st(6'b000100);
        chk({7'h00, tx_irq_o}, 8'h01);
        for (i = 0; i < 13; i++)
        begin
            seed = xs(seed);
            txq[i] = seed[7:0];
            wr(`SFF_IDX_TXD, txq[i], r);
        end
        st(6'b001000);
        chk({7'h00, tx_irq_o}, 8'h00);
        i_mst.sel(1'b1);
        for (i = 0; i < 13; i++)
        begin
            seed = xs(seed);
            rxq[i] = seed[7:0];
            i_mst.xfer(rxq[i], v);
            chk(v, (i < 12) ? txq[i] : 8'hFF);
        end
        i_mst.desel;
        st(6'b110100);
        chk({7'h00, rx_irq_o}, 8'h01);
        for (i = 0; i < 12; i++)
        begin
            rd(`SFF_IDX_RXD, v);
            chk(v, rxq[i]);
        end
        st(6'b100100);
        wr(`SFF_IDX_STAT, 8'hFF, r);
        st(6'b000100);
        for (i = 0; i < 3; i++)
            wr(`SFF_IDX_TXD, txq[i], r);
        i_mst.sel(1'b1);
        i_mst.xfer(8'h5A, v);
        i_mst.desel;
        st(6'b010110);
        wr(`SFF_IDX_TXD, 8'hA5, r);
        st(6'b010000);
        i_mst.sel(1'b1);
        i_mst.xfer(8'h3C, v);
        chk(v, 8'hA5);
        i_mst.desel;
        wr(`SFF_IDX_CTRL, 8'hC6, r);
        i_mst.edge_sel = 1'b1;
        seed = xs(seed);
        wr(`SFF_IDX_TXD, seed[15:8], r);
        i_mst.sel(1'b1);
        i_mst.xfer(seed[7:0], v);
        i_mst.desel;
        chk(v, seed[15:8]);
        rd(`SFF_IDX_RXD, v);
        chk(v, 8'h5A);
        rd(`SFF_IDX_RXD, v);
        chk(v, 8'h3C);
        rd(`SFF_IDX_RXD, v);
        chk(v, seed[7:0]);
        i_mst.edge_sel = 1'b0;
        wr(`SFF_IDX_CTRL, 8'hE2, r);
        seed = xs(seed);
        i_mst.sel(1'b0);
        i_mst.xfer(seed[7:0], v);
        st(6'b000101);
        chk(expanded_select_outputs_o, seed[7:0]);
        chk({7'h00, expander_mode_o}, 8'h01);
        i_mst.desel;
        st(6'b000100);
        chk(expanded_select_outputs_o, 8'hFF);
        wr(10'h3FF, 8'h00, r);
        chk({6'h00, r}, {6'h00, `SFF_RESP_SLVERR});
        rd(10'h3FF, v);
        chk({6'h00, rr}, {6'h00, `SFF_RESP_SLVERR});
        chk(v, 8'h00);
        end_sim;
    end
endmodule : test_spi_fifo_status_flags
